// File: mct_timing.sv
// Issue sequencer that holds each instruction for its exact cycle count.
module mct_timing
  import mct_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic ARST_N,
  // Issue request from the fetch stage.
  input wire logic OP_VALID,
  input wire logic [7:0] OP_CODE,
  input wire logic COND_TRUE,
  // Program store control bits.
  input wire logic PSC_PGM_SEL,
  input wire logic PSC_ERASE_EN,
  // Sequencer status.
  output logic ISSUE_READY,
  output logic OP_TAKEN,
  output logic RETIRE,
  output logic EXEC_BUSY,
  // Decoded attributes of the instruction in execution.
  output mct_len_t INSN_LEN,
  output mct_cyc_t INSN_CYCLES,
  output logic BRANCH_TAKEN,
  output mct_flg_t FLAGS_AFFECTED,
  output logic NOP_EXEC,
  // External-space move steering.
  output logic XMOVE_FLASH,
  output logic XMOVE_XRAM,
  output logic XMOVE_WRITE,
  output logic XMOVE_ERASE
);
  typedef enum logic {ST_IDLE, ST_EXEC} mct_state_t;

  typedef struct packed {
    mct_state_t state;
    logic ready;
    logic taken;
    logic retire;
    logic busy;
    mct_len_t len;
    mct_cyc_t cyc;
    logic br_taken;
    mct_flg_t flags;
    logic nop;
    logic xflash;
    logic xxram;
    logic xwr;
    logic xerase;
    mct_cyc_t gap;
  } mct_seq_t;

  mct_seq_t st_r;
  mct_seq_t st_nxt;

  mct_len_t dec_len;
  mct_cyc_t dec_cyc;
  logic dec_cond;
  mct_flg_t dec_flags;
  logic dec_xmove;
  logic dec_xwr;
  logic dec_nop;
  logic take;
  mct_cyc_t cyc_eff;
  mct_cyc_t cyc_less;
  mct_cnt_t remain;

  mct_decoder u_decoder (
    .op(OP_CODE),
    .len(dec_len),
    .cyc(dec_cyc),
    .cond(dec_cond),
    .flags(dec_flags),
    .xmove(dec_xmove),
    .xmove_wr(dec_xwr),
    .nop(dec_nop)
  );

  // Nothing is accepted while a previous instruction still has cycles left.
  assign take = OP_VALID && st_r.ready;

  // The decoder gives the taken-path time; the fall-through path saves one cycle.
  assign cyc_eff = (dec_cond && !COND_TRUE) ? (dec_cyc - CYC_ONE) : dec_cyc;
  assign cyc_less = cyc_eff - CYC_ONE;

  // The counter holds cycles still to run after the issue cycle.
  mct_cycle_counter #(
    .W(CNT_W)
  ) u_counter (
    .clk(CLK),
    .arst_n(ARST_N),
    .load(take),
    .load_val(cyc_less[CNT_W-1:0]),
    .count(remain)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.taken = take;
    if (take) begin
      st_nxt.ready = (cyc_eff == CYC_ONE);
      st_nxt.retire = st_nxt.ready;
      st_nxt.len = dec_len;
      st_nxt.cyc = cyc_eff;
      st_nxt.br_taken = dec_cond && COND_TRUE;
      st_nxt.flags = dec_flags;
      st_nxt.nop = dec_nop;
      st_nxt.xflash = dec_xmove && PSC_PGM_SEL;
      st_nxt.xxram = dec_xmove && !PSC_PGM_SEL;
      st_nxt.xwr = dec_xmove && dec_xwr;
      // Erase only makes sense for a write into program space.
      st_nxt.xerase = dec_xmove && dec_xwr && PSC_PGM_SEL && PSC_ERASE_EN;
      st_nxt.gap = '0;
    end else begin
      st_nxt.ready = (remain == '0) || (remain == CNT_LAST);
      st_nxt.retire = (remain == CNT_LAST);
      if (st_r.gap != '1) begin
        st_nxt.gap = st_r.gap + CYC_ONE;
      end
    end
    st_nxt.busy = !st_nxt.ready;
    case (st_r.state)
      ST_IDLE: begin
        if (st_nxt.busy) begin
          st_nxt.state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (!st_nxt.busy) begin
          st_nxt.state = ST_IDLE;
        end
      end
      default: st_nxt.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r <= '0;
      st_r.ready <= '1;
      st_r.state <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ISSUE_READY = st_r.ready;
  assign OP_TAKEN = st_r.taken;
  assign RETIRE = st_r.retire;
  assign EXEC_BUSY = st_r.busy;
  assign INSN_LEN = st_r.len;
  assign INSN_CYCLES = st_r.cyc;
  assign BRANCH_TAKEN = st_r.br_taken;
  assign FLAGS_AFFECTED = st_r.flags;
  assign NOP_EXEC = st_r.nop;
  assign XMOVE_FLASH = st_r.xflash;
  assign XMOVE_XRAM = st_r.xxram;
  assign XMOVE_WRITE = st_r.xwr;
  assign XMOVE_ERASE = st_r.xerase;

  // Ready must return exactly when the issued count has run out.
  a_exact_issue_spacing: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(ISSUE_READY) |-> (st_r.gap + CYC_ONE) == INSN_CYCLES)
    else $error("ready returned at the wrong cycle");

  a_hold_while_busy: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && cyc_eff > CYC_ONE) |=> !ISSUE_READY && EXEC_BUSY)
    else $error("next issue not held off");

  a_two_cycle_walk: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && cyc_eff == CYC_TWO) |=> !ISSUE_READY ##1 (ISSUE_READY && RETIRE))
    else $error("two-cycle instruction not timed in clocks");

  a_single_cycle_ready: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && cyc_eff == CYC_ONE) |=> ISSUE_READY && RETIRE && OP_TAKEN)
    else $error("single-cycle instruction stalled issue");

  a_fallthrough_shorter: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && dec_cond) |=>
      INSN_CYCLES == (BRANCH_TAKEN ? $past(dec_cyc) : ($past(dec_cyc) - CYC_ONE)))
    else $error("branch duration does not match its outcome");

  a_xmove_to_flash: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && dec_xmove && PSC_PGM_SEL) |=> XMOVE_FLASH && !XMOVE_XRAM)
    else $error("external move not steered to flash");

  a_xmove_to_xram: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && dec_xmove && !PSC_PGM_SEL) |=> XMOVE_XRAM && !XMOVE_FLASH && !XMOVE_ERASE)
    else $error("external move not steered to data RAM");

  a_arith_timing: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && (OP_CODE[7:4] == ROW_ADD || OP_CODE[7:4] == ROW_ADDC ||
      OP_CODE[7:4] == ROW_SUBB) && OP_CODE[3:0] >= COL_IMM) |=>
      INSN_CYCLES == ($past(OP_CODE[3]) ? CYC_ONE : CYC_TWO) && FLAGS_AFFECTED == FLG_ARITH &&
      INSN_LEN == (($past(OP_CODE[3:0]) <= COL_DIR) ? LEN_TWO : LEN_ONE))
    else $error("add or subtract timing wrong");

  a_logic_acc_timing: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && (OP_CODE[7:4] == ROW_ORL || OP_CODE[7:4] == ROW_ANL ||
      OP_CODE[7:4] == ROW_XRL) && OP_CODE[3:0] >= COL_IMM) |=>
      INSN_CYCLES == ($past(OP_CODE[3]) ? CYC_ONE : CYC_TWO))
    else $error("logic into accumulator timing wrong");

  a_logic_dir_timing: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && (OP_CODE[7:4] == ROW_ORL || OP_CODE[7:4] == ROW_ANL ||
      OP_CODE[7:4] == ROW_XRL) && (OP_CODE[3:0] == COL_DIR_A ||
      OP_CODE[3:0] == COL_DIR_IMM)) |=>
      ($past(OP_CODE[0]) ? (INSN_CYCLES == CYC_THREE && INSN_LEN == LEN_THREE)
                         : (INSN_CYCLES == CYC_TWO && INSN_LEN == LEN_TWO)))
    else $error("logic into direct byte timing wrong");

  a_acc_single_cycle: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && (OP_CODE == OP_CLR_A || OP_CODE == OP_CPL_A || OP_CODE == OP_RL ||
      OP_CODE == OP_RLC || OP_CODE == OP_RR)) |=>
      INSN_CYCLES == CYC_ONE && INSN_LEN == LEN_ONE ##1 1'b1)
    else $error("accumulator operation not single cycle");

  // Bounds on every instruction, with divide as the single longest case.
  a_longest_divide: assert property (@(posedge CLK) disable iff (!ARST_N)
    (INSN_CYCLES <= CYC_MAX) and (st_r.busy |-> st_r.gap < CYC_MAX) and
    ((take && OP_CODE == OP_DIV) |=> INSN_CYCLES == CYC_MAX))
    else $error("instruction exceeds the longest duration");

  a_spare_as_nop: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && OP_CODE == OP_SPARE) |=>
      NOP_EXEC && INSN_CYCLES == CYC_ONE && INSN_LEN == LEN_ONE &&
      FLAGS_AFFECTED == FLG_NONE && !XMOVE_FLASH && !XMOVE_XRAM)
    else $error("spare opcode differs from no-operation");

  a_decode_flags: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && (OP_CODE == OP_MUL || OP_CODE == OP_DIV)) |=>
      FLAGS_AFFECTED == FLG_CY_OV && INSN_LEN == LEN_ONE)
    else $error("multiply or divide flag effects wrong");

  // Every take raises the issue pulse for exactly one cycle.
  a_taken_pulse: assert property (@(posedge CLK) disable iff (!ARST_N)
    take |=> OP_TAKEN)
    else $error("issue pulse missing after take");

  a_no_spurious_take: assert property (@(posedge CLK) disable iff (!ARST_N)
    !take |=> !OP_TAKEN)
    else $error("issue pulse without a take");

  // A request while busy is dropped, not queued, so the fetch stage must hold it.
  a_refused_busy: assert property (@(posedge CLK) disable iff (!ARST_N)
    (OP_VALID && !ISSUE_READY) |=> !OP_TAKEN)
    else $error("request accepted while busy");

  a_retire_on_ready: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(ISSUE_READY) |-> RETIRE)
    else $error("finish without retire pulse");

  // Back-to-back single-cycle issue keeps retire high, so only a new take may extend it.
  a_retire_pulse: assert property (@(posedge CLK) disable iff (!ARST_N)
    RETIRE |-> ISSUE_READY ##1 (!RETIRE || OP_TAKEN))
    else $error("retire pulse stretched");

  a_state_tracks_busy: assert property (@(posedge CLK) disable iff (!ARST_N)
    EXEC_BUSY == (st_r.state == ST_EXEC) && EXEC_BUSY == !ISSUE_READY)
    else $error("busy flag disagrees with sequencer state");

  // Decoded outputs describe the last issued instruction until the next take.
  a_decoded_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
    !take |=> $stable(INSN_CYCLES) && $stable(INSN_LEN) && $stable(FLAGS_AFFECTED) &&
      $stable(BRANCH_TAKEN) && $stable(NOP_EXEC) && $stable(XMOVE_FLASH))
    else $error("decoded outputs changed without a take");

  a_xmove_only: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && !dec_xmove) |=>
      !XMOVE_FLASH && !XMOVE_XRAM && !XMOVE_WRITE && !XMOVE_ERASE)
    else $error("steering raised for an ordinary instruction");

  a_erase_in_flash: assert property (@(posedge CLK) disable iff (!ARST_N)
    XMOVE_ERASE |-> XMOVE_FLASH && XMOVE_WRITE)
    else $error("erase marked outside a flash write");

  a_branch_flag_plain: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && !dec_cond) |=> !BRANCH_TAKEN)
    else $error("taken branch reported for a plain instruction");

  a_nop_only: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && OP_CODE != OP_NOP && OP_CODE != OP_SPARE) |=> !NOP_EXEC)
    else $error("no-operation reported for another opcode");

  // Divide is the longest instruction: ready stays low for seven cycles, then returns.
  a_divide_span: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && OP_CODE == OP_DIV) |=> !ISSUE_READY [*7] ##1 ISSUE_READY)
    else $error("divide does not span eight cycles");

  a_multiply_span: assert property (@(posedge CLK) disable iff (!ARST_N)
    (take && OP_CODE == OP_MUL) |=> !ISSUE_READY [*3] ##1 (ISSUE_READY && RETIRE))
    else $error("multiply not timed in clocks");
endmodule

// File: mct_pkg.sv
// Shared constants and types for the instruction timing block.
package mct_pkg;
  localparam int CNT_W = 3;
  localparam int CYC_W = 4;
  localparam int LEN_W = 2;
  localparam int FLG_W = 3;

  typedef logic [7:0] mct_op_t;
  typedef logic [3:0] mct_nib_t;
  typedef logic [CYC_W-1:0] mct_cyc_t;
  typedef logic [LEN_W-1:0] mct_len_t;
  typedef logic [FLG_W-1:0] mct_flg_t;
  typedef logic [CNT_W-1:0] mct_cnt_t;

  // Instruction lengths in bytes.
  localparam mct_len_t LEN_ONE = 2'h1;
  localparam mct_len_t LEN_TWO = 2'h2;
  localparam mct_len_t LEN_THREE = 2'h3;

  // Execution times in system clock cycles.
  localparam mct_cyc_t CYC_ONE = 4'h1;
  localparam mct_cyc_t CYC_TWO = 4'h2;
  localparam mct_cyc_t CYC_THREE = 4'h3;
  localparam mct_cyc_t CYC_FOUR = 4'h4;
  localparam mct_cyc_t CYC_FIVE = 4'h5;
  localparam mct_cyc_t CYC_DIV = 4'h8;
  localparam mct_cyc_t CYC_MUL = CYC_FOUR;
  localparam mct_cyc_t CYC_MAX = CYC_DIV;
  localparam mct_cnt_t CNT_LAST = 3'h1;

  // Affected-flag masks, carry in the top bit, then aux carry, then overflow.
  localparam mct_flg_t FLG_NONE = 3'h0;
  localparam mct_flg_t FLG_CY = 3'h4;
  localparam mct_flg_t FLG_CY_OV = 3'h5;
  localparam mct_flg_t FLG_ARITH = 3'h7;

  // Opcodes and opcode-map rows that the timing logic singles out.
  localparam mct_op_t OP_NOP = 8'h00;
  localparam mct_op_t OP_SPARE = 8'hA5;
  localparam mct_op_t OP_DIV = 8'h84;
  localparam mct_op_t OP_MUL = 8'hA4;
  localparam mct_op_t OP_DA = 8'hD4;
  localparam mct_op_t OP_RR = 8'h03;
  localparam mct_op_t OP_RRC = 8'h13;
  localparam mct_op_t OP_RL = 8'h23;
  localparam mct_op_t OP_RLC = 8'h33;
  localparam mct_op_t OP_CLR_A = 8'hE4;
  localparam mct_op_t OP_CPL_A = 8'hF4;
  localparam mct_nib_t ROW_ADD = 4'h2;
  localparam mct_nib_t ROW_ADDC = 4'h3;
  localparam mct_nib_t ROW_ORL = 4'h4;
  localparam mct_nib_t ROW_ANL = 4'h5;
  localparam mct_nib_t ROW_XRL = 4'h6;
  localparam mct_nib_t ROW_SUBB = 4'h9;
  localparam mct_nib_t ROW_XMOVE_RD = 4'hE;
  localparam mct_nib_t ROW_XMOVE_WR = 4'hF;
  localparam mct_nib_t COL_DIR_A = 4'h2;
  localparam mct_nib_t COL_DIR_IMM = 4'h3;
  localparam mct_nib_t COL_IMM = 4'h4;
  localparam mct_nib_t COL_DIR = 4'h5;
endpackage

// File: mct_cycle_counter.sv
// Loadable down-counter that holds the remaining execution cycles.
module mct_cycle_counter
  import mct_pkg::*;
#(
  parameter int W = CNT_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Load and count.
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic [W-1:0] count
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } mct_cnt_state_t;

  mct_cnt_state_t st_r;
  mct_cnt_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (load) begin
      st_nxt.cnt = load_val;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count = st_r.cnt;
endmodule

// File: mct_decoder.sv
// Opcode decoder giving length, taken-path cycles, branch class and flag effects.
module mct_decoder
  import mct_pkg::*;
(
  // Opcode in.
  input wire logic [7:0] op,
  // Decoded attributes.
  output mct_len_t len,
  output mct_cyc_t cyc,
  output logic cond,
  output mct_flg_t flags,
  output logic xmove,
  output logic xmove_wr,
  output logic nop
);
  mct_nib_t hi;
  mct_nib_t lo;

  assign hi = op[7:4];
  assign lo = op[3:0];

  // The opcode map is walked by column, since addressing mode follows the low nibble.
  always_comb begin
    len = LEN_ONE;
    cyc = CYC_ONE;
    cond = 1'b0;
    if (lo[3]) begin
      case (hi)
        4'h7, 4'h8, 4'hA: begin len = LEN_TWO; cyc = CYC_TWO; end
        4'hB: begin len = LEN_THREE; cyc = CYC_FOUR; cond = 1'b1; end
        4'hD: begin len = LEN_TWO; cyc = CYC_THREE; cond = 1'b1; end
        default: ;
      endcase
    end else begin
      case (lo[2:0])
        3'h6, 3'h7: begin
          case (hi)
            4'h7, 4'h8, 4'hA: begin len = LEN_TWO; cyc = CYC_TWO; end
            4'hB: begin len = LEN_THREE; cyc = CYC_FIVE; cond = 1'b1; end
            default: cyc = CYC_TWO;
          endcase
        end
        3'h5: begin
          case (hi)
            4'h7, 4'h8: begin len = LEN_THREE; cyc = CYC_THREE; end
            4'hA: ;
            4'hB, 4'hD: begin len = LEN_THREE; cyc = CYC_FOUR; cond = 1'b1; end
            default: begin len = LEN_TWO; cyc = CYC_TWO; end
          endcase
        end
        3'h4: begin
          case (hi)
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: begin len = LEN_TWO; cyc = CYC_TWO; end
            4'h8: cyc = CYC_DIV;
            4'hA: cyc = CYC_MUL;
            4'hB: begin len = LEN_THREE; cyc = CYC_FOUR; cond = 1'b1; end
            default: ;
          endcase
        end
        3'h3: begin
          case (hi)
            4'h4, 4'h5, 4'h6: begin len = LEN_THREE; cyc = CYC_THREE; end
            4'h7, 4'h8, 4'h9, 4'hE, 4'hF: cyc = CYC_THREE;
            default: ;
          endcase
        end
        3'h2: begin
          case (hi)
            4'h0, 4'h1: begin len = LEN_THREE; cyc = CYC_FOUR; end
            4'h2, 4'h3: cyc = CYC_FIVE;
            4'hE, 4'hF: cyc = CYC_THREE;
            default: begin len = LEN_TWO; cyc = CYC_TWO; end
          endcase
        end
        3'h1: begin len = LEN_TWO; cyc = CYC_THREE; end
        default: begin
          case (hi)
            4'h0: ;
            4'h1, 4'h2, 4'h3: begin len = LEN_THREE; cyc = CYC_FOUR; cond = 1'b1; end
            4'h4, 4'h5, 4'h6, 4'h7: begin len = LEN_TWO; cyc = CYC_THREE; cond = 1'b1; end
            4'h8: begin len = LEN_TWO; cyc = CYC_THREE; end
            4'h9: begin len = LEN_THREE; cyc = CYC_THREE; end
            4'hE, 4'hF: cyc = CYC_THREE;
            default: begin len = LEN_TWO; cyc = CYC_TWO; end
          endcase
        end
      endcase
    end
  end

  // Parity follows the accumulator continuously, so it is not part of this mask.
  always_comb begin
    flags = FLG_NONE;
    if ((hi == ROW_ADD || hi == ROW_ADDC || hi == ROW_SUBB) && (lo >= COL_IMM)) begin
      flags = FLG_ARITH;
    end else if (op == OP_MUL || op == OP_DIV) begin
      flags = FLG_CY_OV;
    end else if (op == OP_DA || op == OP_RRC || op == OP_RLC) begin
      flags = FLG_CY;
    end else if ((hi == 4'hB) && (lo >= COL_IMM)) begin
      flags = FLG_CY;
    end else if (((hi == 4'hB || hi == 4'hC || hi == 4'hD) && lo == COL_DIR_IMM) ||
                 ((hi == 4'h7 || hi == 4'h8 || hi == 4'hA) && lo == COL_DIR_A) ||
                 ((hi == 4'hA || hi == 4'hB) && lo == 4'h0)) begin
      flags = FLG_CY;
    end
  end

  assign xmove = (hi == ROW_XMOVE_RD || hi == ROW_XMOVE_WR) &&
                 (lo == 4'h0 || lo == COL_DIR_A || lo == COL_DIR_IMM);
  assign xmove_wr = (hi == ROW_XMOVE_WR);
  assign nop = (op == OP_NOP) || (op == OP_SPARE);
endmodule

// File: mct_mem_model.sv
// Behavioural model of on-chip program flash and external data RAM behind the move steering.
module mct_mem_model
  import mct_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Steering from the sequencer.
  input wire logic taken,
  input wire logic flash_sel,
  input wire logic xram_sel,
  input wire logic wr,
  input wire logic erase,
  // Access tallies for the bench.
  output logic [7:0] flash_rd,
  output logic [7:0] flash_wr,
  output logic [7:0] xram_rd,
  output logic [7:0] xram_wr
);
  timeunit 1ns;
  timeprecision 1ns;

  // Each access is counted once, on the issue pulse, because the steering levels persist.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_rd <= 8'h00;
      flash_wr <= 8'h00;
      xram_rd <= 8'h00;
      xram_wr <= 8'h00;
    end else if (taken) begin
      if (flash_sel && wr) flash_wr <= flash_wr + 8'h01;
      if (flash_sel && !wr) flash_rd <= flash_rd + 8'h01;
      if (xram_sel && wr) xram_wr <= xram_wr + 8'h01;
      if (xram_sel && !wr) xram_rd <= xram_rd + 8'h01;
    end
  end
endmodule

// File: mcu_core_instruction_timing_bench.sv
// Self-checking bench for the instruction timing sequencer.
module mcu_core_instruction_timing_bench
  import mct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, arst_n, op_valid, cond_true, psc_pgm_sel, psc_erase_en;
  mct_op_t op_code;
  logic issue_ready, op_taken, retire, exec_busy, branch_taken, nop_exec;
  logic xmove_flash, xmove_xram, xmove_write, xmove_erase;
  mct_len_t insn_len;
  mct_cyc_t insn_cycles;
  mct_flg_t flags_affected;
  logic [7:0] f_rd, f_wr, x_rd, x_wr;
  int mismatches = 0;
  int checked = 0;
  int ef_rd, ef_wr, ex_rd, ex_wr;

  mct_timing dut_u (.CLK(clk), .ARST_N(arst_n), .OP_VALID(op_valid), .OP_CODE(op_code),
    .COND_TRUE(cond_true), .PSC_PGM_SEL(psc_pgm_sel), .PSC_ERASE_EN(psc_erase_en),
    .ISSUE_READY(issue_ready), .OP_TAKEN(op_taken), .RETIRE(retire), .EXEC_BUSY(exec_busy),
    .INSN_LEN(insn_len), .INSN_CYCLES(insn_cycles), .BRANCH_TAKEN(branch_taken),
    .FLAGS_AFFECTED(flags_affected), .NOP_EXEC(nop_exec), .XMOVE_FLASH(xmove_flash),
    .XMOVE_XRAM(xmove_xram), .XMOVE_WRITE(xmove_write), .XMOVE_ERASE(xmove_erase));

  mct_mem_model mem_u (.clk(clk), .arst_n(arst_n), .taken(op_taken), .flash_sel(xmove_flash),
    .xram_sel(xmove_xram), .wr(xmove_write), .erase(xmove_erase), .flash_rd(f_rd),
    .flash_wr(f_wr), .xram_rd(x_rd), .xram_wr(x_wr));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge clk);
    #10;
  endtask

  // Reference timing; zero length means the opcode is outside the modelled classes.
  function automatic void ref_of(input mct_op_t op, input logic c, output int len,
      output int cyc, output int flg, output int br);
    logic [3:0] hi, lo;
    int tk;
    hi = op[7:4];
    lo = op[3:0];
    len = 0;
    cyc = 0;
    flg = 0;
    br = 0;
    tk = 0;
    if (op == 8'h00 || op == 8'hA5) begin len = 1; cyc = 1; end
    else if (op == 8'h84) begin len = 1; cyc = 8; flg = 5; end
    else if (op == 8'hA4) begin len = 1; cyc = 4; flg = 5; end
    else if (op == 8'hD4 || op == 8'h13 || op == 8'h33) begin len = 1; cyc = 1; flg = 4; end
    else if (op == 8'h03 || op == 8'h23 || op == 8'hE4 || op == 8'hF4) begin len = 1; cyc = 1; end
    else if (hi inside {2, 3, 9, 4, 5, 6} && lo >= 4) begin
      len = (lo >= 6) ? 1 : 2;
      cyc = (lo >= 8) ? 1 : 2;
      flg = (hi inside {2, 3, 9}) ? 7 : 0;
    end
    else if (hi inside {4, 5, 6} && lo == 2) begin len = 2; cyc = 2; end
    else if (hi inside {4, 5, 6} && lo == 3) begin len = 3; cyc = 3; end
    else if (hi >= 4'hE && lo inside {0, 2, 3}) begin len = 1; cyc = 3; end
    else if (hi inside {4, 5, 6, 7} && lo == 0) begin len = 2; tk = 3; end
    else if (hi inside {1, 2, 3} && lo == 0) begin len = 3; tk = 4; end
    else if (hi == 4'hB && lo >= 4) begin len = 3; tk = (lo inside {6, 7}) ? 5 : 4; flg = 4; end
    else if (hi == 4'hD && lo >= 8) begin len = 2; tk = 3; end
    else if (op == 8'hD5) begin len = 3; tk = 4; end
    if (tk != 0) begin
      br = c;
      cyc = c ? tk : tk - 1;
    end
  endfunction

  // Takes one opcode and follows it until the sequencer is ready again.
  task automatic issue(input mct_op_t op, input logic c, input logic pgm, input logic ers);
    int len, cyc, flg, br, n;
    logic xm, wr;
    ref_of(op, c, len, cyc, flg, br);
    xm = op[7:5] == 3'h7 && op[3:0] inside {4'h0, 4'h2, 4'h3};
    wr = op[4];
    op_valid = 1'b1;
    op_code = op;
    cond_true = c;
    psc_pgm_sel = pgm;
    psc_erase_en = ers;
    step();
    chk(op_taken, 8'h01);
    chk(nop_exec, (op == 8'h00 || op == 8'hA5));
    chk(xmove_flash, xm && pgm);
    chk(xmove_xram, xm && !pgm);
    chk(xmove_write, xm && wr);
    chk(xmove_erase, xm && wr && pgm && ers);
    if (len != 0) begin
      chk(insn_cycles, 8'(cyc));
      chk(insn_len, 8'(len));
      chk(flags_affected, 8'(flg));
      chk(branch_taken, 8'(br));
    end
    if (xm) begin
      if (pgm && wr) ef_wr++;
      if (pgm && !wr) ef_rd++;
      if (!pgm && wr) ex_wr++;
      if (!pgm && !wr) ex_rd++;
    end
    // A changed opcode while busy must be refused, not queued.
    if (insn_cycles > 4'h1) op_code = 8'($urandom);
    n = 1;
    while (issue_ready !== 1'b1 && n < 12) begin
      chk(exec_busy, 8'h01);
      step();
      n++;
    end
    chk(8'(n), insn_cycles);
    chk(n <= 8, 8'h01);
    chk(retire, 8'h01);
    if (len != 0) chk(insn_cycles, 8'(cyc));
  endtask

  task automatic idle(input int k);
    op_valid = 1'b0;
    op_code = 8'($urandom);
    step();
    chk(op_taken, 8'h00);
    chk(f_rd, 8'(ef_rd));
    chk(f_wr, 8'(ef_wr));
    chk(x_rd, 8'(ex_rd));
    chk(x_wr, 8'(ex_wr));
    repeat (k - 1) step();
  endtask

  task automatic do_reset();
    arst_n = 1'b0;
    op_valid = 1'b0;
    ef_rd = 0;
    ef_wr = 0;
    ex_rd = 0;
    ex_wr = 0;
    repeat (5) step();
    chk(issue_ready, 8'h01);
    chk(op_taken, 8'h00);
    chk(insn_cycles, 8'h00);
    chk(xmove_flash, 8'h00);
    arst_n = 1'b1;
  endtask

  initial begin
    logic [3:0] rows [6];
    mct_op_t accs [11];
    mct_op_t brs [13];
    mct_op_t xms [6];
    rows = '{4'h2, 4'h3, 4'h9, 4'h4, 4'h5, 4'h6};
    accs = '{8'h00, 8'hA5, 8'h84, 8'hA4, 8'hD4, 8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13};
    brs = '{8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'hB4, 8'hB5, 8'hB6, 8'hB8,
      8'hD5, 8'hD8};
    xms = '{8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3};
    arst_n = 1'b0;
    op_valid = 1'b0;
    op_code = 8'h00;
    cond_true = 1'b0;
    psc_pgm_sel = 1'b0;
    psc_erase_en = 1'b0;
    void'($urandom(99364));
    do_reset();
    for (int r = 0; r < 6; r++) begin
      for (int lo = 2; lo < 16; lo++) issue({rows[r], 4'(lo)}, 1'b0, 1'b0, 1'b0);
    end
    foreach (accs[i]) issue(accs[i], 1'b1, 1'b0, 1'b0);
    foreach (brs[i]) begin
      issue(brs[i], 1'b1, 1'b0, 1'b0);
      issue(brs[i], 1'b0, 1'b0, 1'b0);
    end
    for (int i = 0; i < 24; i++) begin
      issue(xms[i % 6], 1'b0, 1'(i / 6), 1'(i / 12));
      idle(1);
    end
    // Reset in the middle of a long divide must abandon it.
    op_valid = 1'b1;
    op_code = 8'h84;
    step();
    op_valid = 1'b0;
    step();
    chk(exec_busy, 8'h01);
    do_reset();
    repeat (300) begin
      issue(8'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
      if ($urandom % 4 == 0) idle(1 + $urandom % 3);
    end
    idle(2);
    summarize();
  end

  initial begin
    #2000000;
    mismatches++;
    summarize();
  end
endmodule
